// ==== core/iocs_pkg.sv ====
// Shared constants and types for the I/O cell storage logic
package iocs_pkg;
   localparam int unsigned NUM_ELEM      = 6;
   localparam int unsigned ELEM_W        = 5;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned CLK_PERIOD_NS = 20;

   // Register byte addresses
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_ELEM     = 8'h04;
   localparam logic [7:0]  ADDR_STAT     = 8'h08;

   // Control register layout
   localparam int unsigned CTRL_W        = 17;
   localparam int unsigned CTRL_IN_LSB   = 0;
   localparam int unsigned CTRL_OUT_LSB  = 2;
   localparam int unsigned CTRL_TS_LSB   = 4;
   localparam int unsigned CTRL_ASYNC    = 6;
   localparam int unsigned CTRL_FWD      = 7;
   localparam int unsigned CTRL_GINIT    = 8;
   localparam int unsigned CTRL_INV_LSB  = 9;
   localparam int unsigned CTRL_USED_LSB = 14;
   localparam logic [16:0] CTRL_RST      = 17'h00000;
   localparam logic [16:0] CTRL_WR_MASK  = 17'h1FEFF;

   // Polarity bit order inside the inversion field
   localparam int unsigned INV_ICE       = 0;
   localparam int unsigned INV_OCE       = 1;
   localparam int unsigned INV_TCE       = 2;
   localparam int unsigned INV_SR        = 3;
   localparam int unsigned INV_REV       = 4;

   // Per element configuration field
   localparam int unsigned ELEM_BITS     = 30;
   localparam int unsigned F_LATCH       = 0;
   localparam int unsigned F_SRVAL       = 1;
   localparam int unsigned F_INIT        = 2;
   localparam int unsigned F_SETEN       = 3;
   localparam int unsigned F_RSTEN       = 4;
   localparam logic [29:0] ELEM_RST      = 30'h00000000;

   // Phase divider: fabric clock is the system clock divided by four
   localparam int unsigned DIV_W         = 2;
   localparam logic [1:0]  DIV_RISE_A    = 2'h2;
   localparam logic [1:0]  DIV_RISE_B    = 2'h0;
   localparam logic [1:0]  DIV_RST       = 2'h0;

   typedef enum logic [1:0] {
      MODE_DIRECT = 2'h0,
      MODE_SINGLE = 2'h1,
      MODE_DDR    = 2'h2
   } iocs_mode_t;
endpackage

// ==== core/iocs_elem.sv ====
// One storage element: flip-flop or latch with set/reset options
`timescale 1ns/1ps
module iocs_elem
   import iocs_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_rst_b,
   input  wire logic i_d,
   input  wire logic i_gate,
   input  wire logic i_gate_rise,
   input  wire logic i_ce,
   input  wire logic i_sr,
   input  wire logic i_rev,
   input  wire logic i_async,
   input  wire logic i_latch,
   input  wire logic i_srval,
   input  wire logic i_init,
   input  wire logic i_set_en,
   input  wire logic i_rst_en,
   input  wire logic i_load_init,
   output logic      o_q
);
   logic q_q;
   logic q_d;
   wire  set_req   = i_srval ? i_sr : i_rev;
   wire  rst_req   = i_srval ? i_rev : i_sr;
   wire  set_act   = set_req & i_set_en;
   wire  rst_act   = rst_req & i_rst_en;
   wire  force_hit = set_act | rst_act;
   wire  force_val = ~rst_act;
   wire  async_hit = i_async & force_hit;
   // Latch follows D for the whole active level, flop only at the rising step
   wire  cap       = i_latch ? i_gate : i_gate_rise;

   always_comb begin
      if (async_hit) begin
         q_d = force_val;
      end else if (i_load_init) begin
         q_d = i_init;
      end else if (cap && force_hit) begin
         q_d = force_val;
      end else if (cap && i_ce) begin
         q_d = i_d;
      end else begin
         q_d = q_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end

   // Asynchronous forcing shows at once, not only after the next edge
   assign o_q = async_hit ? force_val : q_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   a_clear_over_preset: assert property (async_hit && rst_act |-> o_q == 1'b0)
      else $error("async clear did not override preset");
   a_sync_force_value: assert property (!i_async && cap && force_hit && !i_load_init
      |=> q_q == $past(force_val))
      else $error("sync force loaded wrong value");
   a_flop_hold: assert property (!i_latch && !i_gate_rise && !force_hit && !i_load_init
      |=> $stable(q_q))
      else $error("flip-flop changed without a clock step");
   a_latch_follow: assert property (i_latch && i_gate && i_ce && !force_hit && !i_load_init
      |=> q_q == $past(i_d))
      else $error("open latch did not follow data");
   a_ce_blocks_load: assert property (!i_ce && !force_hit && !i_load_init
      |=> $stable(q_q))
      else $error("element loaded with clock enable low");
   a_init_value: assert property (i_load_init && !async_hit |=> q_q == $past(i_init))
      else $error("global init did not load initial value");
endmodule

// ==== core/iocs_cell.sv ====
// I/O cell storage logic: input, output and tri-state paths with APB config
`timescale 1ns/1ps
module iocs_cell
   import iocs_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst_b,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   input  wire logic              i_pad_in,
   output logic                   o_pad_out,
   output logic                   o_pad_oe,
   output logic                   o_fab_in_a,
   output logic                   o_fab_in_b,
   input  wire logic              i_fab_out_a,
   input  wire logic              i_fab_out_b,
   input  wire logic              i_fab_ts_a,
   input  wire logic              i_fab_ts_b,
   input  wire logic              i_input_pair_clk_en,
   input  wire logic              i_output_pair_clk_en,
   input  wire logic              i_tristate_pair_clk_en,
   input  wire logic              i_shared_set_reset,
   input  wire logic              i_reverse_force
);
   logic [CTRL_W-1:0]    ctrl_q;
   logic [ELEM_BITS-1:0] elem_cfg_q;
   logic                 ginit_q;
   logic [DIV_W-1:0]     div_q;
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic                 pad_out_q;
   logic                 pad_oe_q;
   logic                 fab_in_a_q;
   logic                 fab_in_b_q;
   logic [2:0]           fwd_cnt_q;

   // APB decode
   wire        setup      = i_psel & ~i_penable;
   wire        access     = i_psel & i_penable & pready_q;
   wire        wr         = access & i_pwrite;
   wire        hit_ctrl   = (i_paddr == ADDR_CTRL);
   wire        hit_elem   = (i_paddr == ADDR_ELEM);
   wire        hit_stat   = (i_paddr == ADDR_STAT);
   wire        hit_any    = hit_ctrl | hit_elem | hit_stat;
   wire [31:0] rd_ctrl    = {15'h0000, ctrl_q};
   wire [31:0] rd_elem    = {2'h0, elem_cfg_q};
   wire [5:0]  el_q;
   wire [31:0] rd_stat    = {21'h000000, pad_oe_q, pad_out_q, fab_in_b_q, fab_in_a_q, div_q[1], el_q};
   logic [31:0] rd_data;

   always_comb begin
      if (hit_ctrl) begin
         rd_data = rd_ctrl;
      end else if (hit_elem) begin
         rd_data = rd_elem;
      end else if (hit_stat) begin
         rd_data = rd_stat;
      end else begin
         rd_data = 32'h00000000;
      end
   end

   // Configuration fields
   wire iocs_mode_t in_mode  = iocs_mode_t'(ctrl_q[CTRL_IN_LSB +: 2]);
   wire iocs_mode_t out_mode = iocs_mode_t'(ctrl_q[CTRL_OUT_LSB +: 2]);
   wire iocs_mode_t ts_mode  = iocs_mode_t'(ctrl_q[CTRL_TS_LSB +: 2]);
   wire       async_sel = ctrl_q[CTRL_ASYNC];
   wire       fwd_sel   = ctrl_q[CTRL_FWD];
   wire [4:0] inv       = ctrl_q[CTRL_INV_LSB +: 5];
   wire [2:0] ce_used   = ctrl_q[CTRL_USED_LSB +: 3];

   // Polarity applied inside the cell, no fabric inverter needed
   wire input_pair_clk_en = ce_used[0] ? (i_input_pair_clk_en ^ inv[INV_ICE]) : 1'b1;
   wire output_pair_clk_en = ce_used[1] ? (i_output_pair_clk_en ^ inv[INV_OCE]) : 1'b1;
   wire tristate_pair_clk_en = ce_used[2] ? (i_tristate_pair_clk_en ^ inv[INV_TCE]) : 1'b1;
   wire sr  = i_shared_set_reset ^ inv[INV_SR];
   wire reverse_force = i_reverse_force ^ inv[INV_REV];

   // Divided fabric clock; the two DDR gates are its two opposite phases
   wire ph     = div_q[1];
   wire rise_a = (div_q == DIV_RISE_A);
   wire rise_b = (div_q == DIV_RISE_B);

   // Element order: input A/B, output A/B, tri-state A/B
   wire [5:0] el_d    = {i_fab_ts_b, i_fab_ts_a,
                         fwd_sel ? 1'b0 : i_fab_out_b,
                         fwd_sel ? 1'b1 : i_fab_out_a,
                         i_pad_in, i_pad_in};
   wire [5:0] el_gate = {~ph, ph, ~ph, ph, ~ph, ph};
   wire [5:0] el_rise = {rise_b, rise_a, rise_b, rise_a, rise_b, rise_a};
   wire [5:0] el_ce   = {tristate_pair_clk_en, tristate_pair_clk_en, output_pair_clk_en, output_pair_clk_en, input_pair_clk_en, input_pair_clk_en};

   for (genvar g = 0; g < NUM_ELEM; g++) begin : g_el
      iocs_elem u_el (
         .i_clock     (i_clock),
         .i_rst_b     (i_rst_b),
         .i_d         (el_d[g]),
         .i_gate      (el_gate[g]),
         .i_gate_rise (el_rise[g]),
         .i_ce        (el_ce[g]),
         .i_sr        (sr),
         .i_rev       (reverse_force),
         .i_async     (async_sel),
         .i_latch     (elem_cfg_q[g*ELEM_W+F_LATCH]),
         .i_srval     (elem_cfg_q[g*ELEM_W+F_SRVAL]),
         .i_init      (elem_cfg_q[g*ELEM_W+F_INIT]),
         .i_set_en    (elem_cfg_q[g*ELEM_W+F_SETEN]),
         .i_rst_en    (elem_cfg_q[g*ELEM_W+F_RSTEN]),
         .i_load_init (ginit_q),
         .o_q         (el_q[g])
      );
   end

   // Path selection; output and tri-state DDR pairs are shown one per phase, the input pair on both fabric outputs at once
   wire in_a_sel  = (in_mode == MODE_SINGLE || in_mode == MODE_DDR) ? el_q[0] : i_pad_in;
   wire in_b_sel  = (in_mode == MODE_DDR) ? el_q[1] : 1'b0;
   wire out_sel   = (out_mode == MODE_DDR) ? (ph ? el_q[2] : el_q[3]) :
                    (out_mode == MODE_SINGLE) ? el_q[2] : i_fab_out_a;
   wire ts_sel    = (ts_mode == MODE_DDR) ? (ph ? el_q[4] : el_q[5]) :
                    (ts_mode == MODE_SINGLE) ? el_q[4] : i_fab_ts_a;
   wire fwd_clean = fwd_sel & (out_mode == MODE_DDR) & output_pair_clk_en & ~sr & ~reverse_force & ~ginit_q;

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q     <= CTRL_RST;
         elem_cfg_q <= ELEM_RST;
         ginit_q    <= 1'b0;
      end else begin
         if (wr && hit_ctrl) begin
            ctrl_q <= i_pwdata[CTRL_W-1:0] & CTRL_WR_MASK;
         end
         if (wr && hit_elem) begin
            elem_cfg_q <= i_pwdata[ELEM_BITS-1:0];
         end
         ginit_q <= wr & hit_ctrl & i_pwdata[CTRL_GINIT];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         prdata_q  <= (setup && !i_pwrite) ? rd_data : 32'h00000000;
         pslverr_q <= setup & ~hit_any;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_q      <= DIV_RST;
         pad_out_q  <= 1'b0;
         pad_oe_q   <= 1'b0;
         fab_in_a_q <= 1'b0;
         fab_in_b_q <= 1'b0;
      end else begin
         div_q      <= div_q + 2'h1;
         pad_out_q  <= out_sel;
         pad_oe_q   <= ~ts_sel;
         fab_in_a_q <= in_a_sel;
         fab_in_b_q <= in_b_sel;
      end
   end

   // Helper count of steady forwarding cycles for the check below
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fwd_cnt_q <= 3'h0;
      end else if (!fwd_clean) begin
         fwd_cnt_q <= 3'h0;
      end else if (fwd_cnt_q != 3'h7) begin
         fwd_cnt_q <= fwd_cnt_q + 3'h1;
      end
   end

   assign o_prdata   = prdata_q;
   assign o_pready   = pready_q;
   assign o_pslverr  = pslverr_q;
   assign o_pad_out  = pad_out_q;
   assign o_pad_oe   = pad_oe_q;
   assign o_fab_in_a = fab_in_a_q;
   assign o_fab_in_b = fab_in_b_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence s_fwd_high;
      o_pad_out [*2];
   endsequence
   sequence s_fwd_low;
      !o_pad_out [*2];
   endsequence

   a_clock_forward: assert property (fwd_cnt_q == 3'h7 && div_q == 2'h3 && fwd_clean [*1]
      |-> s_fwd_high ##1 s_fwd_low)
      else $error("forwarded clock pattern wrong at pad");
   a_ddr_alternate: assert property (out_mode == MODE_DDR && ph
      |=> o_pad_out == $past(el_q[2]))
      else $error("DDR output did not show first element in high phase");
   a_phase_opposite: assert property (rise_a |-> ##2 rise_b ##2 rise_a)
      else $error("DDR capture phases not opposite");
   a_apb_one_wait: assert property (setup |=> o_pready ##1 !o_pready)
      else $error("APB ready not a single access cycle");
   a_input_direct: assert property (in_mode == MODE_DIRECT |=> o_fab_in_a == $past(i_pad_in))
      else $error("direct input path broken");
endmodule

// ==== tb/iocs_far_model.sv ====
// Far-side model: fabric drivers and pad source for the I/O cell
`timescale 1ns/1ps
module iocs_far_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic       i_stall,
   input  wire logic [4:0] i_pat,
   output logic            o_pad_in,
   output logic            o_fab_out_a,
   output logic            o_fab_out_b,
   output logic            o_fab_ts_a,
   output logic            o_fab_ts_b
);
   // Stall keeps the last pattern, as a slow fabric would
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {o_pad_in, o_fab_out_a, o_fab_out_b, o_fab_ts_a, o_fab_ts_b} <= 5'h00;
      end else if (!i_stall) begin
         {o_pad_in, o_fab_out_a, o_fab_out_b, o_fab_ts_a, o_fab_ts_b} <= i_pat;
      end
   end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the I/O cell storage logic
`timescale 1ns/1ps
module tb_top
   import iocs_pkg::*;
;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} iocs_exp_t;
   logic        clk = 1'b0;
   logic        rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pad_in, pad_out, pad_oe, in_a, in_b, out_a, out_b, ts_a, ts_b;
   logic        input_pair_clk_en, output_pair_clk_en, tristate_pair_clk_en, sr, reverse_force, stall, v;
   logic [4:0]  pat;
   logic [2:0]  r;
   logic [7:0]  s;
   iocs_exp_t   q[$];
   iocs_exp_t   x;
   int          err_total = 0;
   int          checked = 0;

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   iocs_cell u_iocs_cell (.i_clock(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
      .o_fab_in_a(in_a), .o_fab_in_b(in_b), .i_fab_out_a(out_a), .i_fab_out_b(out_b),
      .i_fab_ts_a(ts_a), .i_fab_ts_b(ts_b), .i_input_pair_clk_en(input_pair_clk_en), .i_output_pair_clk_en(output_pair_clk_en),
      .i_tristate_pair_clk_en(tristate_pair_clk_en), .i_shared_set_reset(sr), .i_reverse_force(reverse_force));

   iocs_far_model u_iocs_far_model (.i_clock(clk), .i_rst_b(rst_b), .i_stall(stall), .i_pat(pat),
      .o_pad_in(pad_in), .o_fab_out_a(out_a), .o_fab_out_b(out_b), .o_fab_ts_a(ts_a), .o_fab_ts_b(ts_b));

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expectation is queued before the request goes out
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
      int n;
      n = 0;
      q.push_back('{d, (w ? 32'h0 : m), e});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         $display("ERROR %0t: no ready", $time);
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      xfer(1'b0, a, d, m, 1'b0);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            x = q.pop_front();
            chk(prdata & x.m, x.d & x.m);
            chk({31'h0, pslverr}, {31'h0, x.e});
         end
      end
   end

   initial begin
      {psel, penable, pwrite, input_pair_clk_en, output_pair_clk_en, tristate_pair_clk_en, sr, reverse_force, stall} = 9'h000;
      paddr = 8'h00;
      pwdata = 32'h0;
      pat = 5'h00;
      rst_b = 1'b0;
      void'($urandom(32'h7A23));
      cyc(5);
      rst_b <= 1'b1;
      rd(ADDR_CTRL, {15'h0, CTRL_RST}, 32'hFFFFFFFF);
      rd(ADDR_ELEM, {2'h0, ELEM_RST}, 32'hFFFFFFFF);
      xfer(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1'b1);
      wr(ADDR_CTRL, 32'h0001FFFF);
      rd(ADDR_CTRL, {15'h0, CTRL_WR_MASK}, 32'hFFFFFFFF);
      wr(ADDR_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         r = 3'($urandom());
         pat <= {r[0], r[1], 1'b0, r[2], 1'b0};
         cyc(4);
         rd(ADDR_STAT, {21'h0, ~r[2], r[1], 1'b0, r[0], 7'h0}, 32'h00000780);
      end
      // Element 0 kept capturing the random pad level; settle it to 0 before gating it
      pat <= 5'h00;
      cyc(8);
      wr(ADDR_CTRL, 32'h00004001);
      pat <= 5'h10;
      cyc(8);
      rd(ADDR_STAT, 32'h0, 32'h00000081);
      input_pair_clk_en <= 1'b1;
      cyc(8);
      rd(ADDR_STAT, 32'h81, 32'h00000081);
      wr(ADDR_CTRL, 32'h00004201);
      pat <= 5'h00;
      cyc(8);
      rd(ADDR_STAT, 32'h1, 32'h00000001);
      input_pair_clk_en <= 1'b0;
      cyc(8);
      rd(ADDR_STAT, 32'h0, 32'h00000001);
      wr(ADDR_CTRL, 32'h00000001);
      pat <= 5'h10;
      cyc(8);
      rd(ADDR_STAT, 32'h1, 32'h00000001);
      for (int f = 0; f < 2; f++) begin
         wr(ADDR_CTRL, (f == 1) ? 32'h00000088 : 32'h00000008);
         pat <= (f == 1) ? 5'h04 : 5'h08;
         cyc(8);
         for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            s[j] = pad_out;
         end
         chk({30'h0, s[7:4] === s[3:0], s[1:0] === ~s[3:2]}, 32'h3);
      end
      // Output pair disabled so only forcing moves element 2
      wr(ADDR_CTRL, 32'h00008044);
      for (int k = 0; k < 2; k++) begin
         v = k[0];
         wr(ADDR_ELEM, {17'h0, 2'b11, 1'b0, v, 1'b0, 10'h0});
         reverse_force <= 1'b1;
         cyc(3);
         rd(ADDR_STAT, {29'h0, ~v, 2'h0}, 32'h4);
         sr <= 1'b1;
         reverse_force <= 1'b0;
         cyc(3);
         rd(ADDR_STAT, {29'h0, v, 2'h0}, 32'h4);
         reverse_force <= 1'b1;
         cyc(3);
         rd(ADDR_STAT, 32'h0, 32'h4);
         sr <= 1'b0;
         reverse_force <= 1'b0;
      end
      wr(ADDR_ELEM, {17'h0, 2'b00, 1'b0, 1'b1, 1'b0, 10'h0});
      sr <= 1'b1;
      cyc(3);
      rd(ADDR_STAT, 32'h0, 32'h4);
      sr <= 1'b0;
      wr(ADDR_ELEM, {17'h0, 2'b10, 1'b1, 1'b0, 1'b0, 10'h0});
      wr(ADDR_CTRL, 32'h00008144);
      cyc(2);
      rd(ADDR_STAT, 32'h4, 32'h4);
      wr(ADDR_CTRL, 32'h00008004);
      sr <= 1'b1;
      cyc(8);
      rd(ADDR_STAT, 32'h0, 32'h4);
      sr <= 1'b0;
      // Input element 0 as latch, single input mode, enable unconnected
      wr(ADDR_ELEM, 32'h00000001);
      wr(ADDR_CTRL, 32'h00000001);
      pat <= 5'h10;
      cyc(8);
      rd(ADDR_STAT, 32'h81, 32'h00000081);
      pat <= 5'h00;
      cyc(8);
      rd(ADDR_STAT, 32'h0, 32'h00000081);
      cyc(2);
      chk(q.size(), 32'h0);
      end_of_test();
   end
endmodule
